// file: hw/eeprom_sync2.sv
`default_nettype none
module eeprom_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// file: hw/spi_eeprom_command_protect.sv
`default_nettype none
module spi_eeprom_command_protect #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  // write guard pin
  input wire logic wp_n_i
);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------
  // link domain: input side
  // ----------------------------------------
  logic fresh;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic addr_hi;
  logic [4:0] in_page;
  logic [31:0] load_mask;
  logic [11:0] rd_ptr;
  eeprom_pkg::link_state_type lstate;
  eeprom_pkg::session_type sess;
  logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0] stat_link;

  wire logic [2:0] cur_bits = fresh ? eeprom_pkg::FIRST_BIT : bit_cnt;
  wire eeprom_pkg::link_state_type cur_state = fresh ? eeprom_pkg::LK_CMD : lstate;
  wire logic byte_done = (cur_bits == eeprom_pkg::LAST_BIT);
  wire logic [7:0] rx_byte = {rx_sh[6:0], si_i};
  wire eeprom_pkg::op_type rx_op = eeprom_pkg::decode_op(rx_byte);
  wire logic busy_link = stat_link[eeprom_pkg::BIT_BUSY];
  wire logic cmd_ok = !busy_link || (rx_op == eeprom_pkg::OP_RDSTAT);
  wire eeprom_pkg::op_type acc_op = cmd_ok ? rx_op : eeprom_pkg::OP_NONE;
  wire logic addr_hi_b = fresh ? 1'b0 : addr_hi;
  wire logic got_b = fresh ? 1'b0 : sess.got_byte;
  wire logic [31:0] mask_b = fresh ? 32'h0 : load_mask;
  wire logic wr_byte = byte_done && (cur_state == eeprom_pkg::LK_WDATA);
  wire logic [4:0] next_in_page = in_page + 5'h1;

  // mode 0 and mode 3 both sample on the rising edge
  always_ff @(posedge sck_i or posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i || cs_n_i) begin
      fresh <= 1'b1;
    end else if (hold_n_i) begin
      fresh <= 1'b0;
    end
  end

  function automatic eeprom_pkg::link_state_type after_cmd(input eeprom_pkg::op_type op);
    unique case (op)
      eeprom_pkg::OP_READ, eeprom_pkg::OP_WRITE: after_cmd = eeprom_pkg::LK_ADDR;
      eeprom_pkg::OP_RDSTAT: after_cmd = eeprom_pkg::LK_STAT_OUT;
      eeprom_pkg::OP_WRSTAT: after_cmd = eeprom_pkg::LK_STAT_IN;
      default: after_cmd = eeprom_pkg::LK_IGNORE;
    endcase
  endfunction

  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= eeprom_pkg::FIRST_BIT;
      rx_sh <= 8'h00;
      addr_hi <= 1'b0;
      in_page <= 5'h00;
      load_mask <= 32'h0;
      rd_ptr <= 12'h000;
      lstate <= eeprom_pkg::LK_CMD;
      sess <= '0;
    end else if (hold_n_i && !cs_n_i) begin
      bit_cnt <= cur_bits + 3'h1;
      rx_sh <= rx_byte;
      sess.aligned <= byte_done;
      sess.extra <= !fresh && (sess.extra || (cur_state != eeprom_pkg::LK_CMD));
      addr_hi <= addr_hi_b;
      sess.got_byte <= got_b;
      load_mask <= mask_b;
      if (byte_done) begin
        unique case (cur_state)
          eeprom_pkg::LK_CMD: begin
            sess.op <= acc_op;
            lstate <= after_cmd(acc_op);
          end
          eeprom_pkg::LK_ADDR: begin
            if (!addr_hi_b) begin
              addr_hi <= 1'b1;
              sess.addr[11:8] <= rx_byte[3:0];
            end else begin
              sess.addr[7:0] <= rx_byte;
              rd_ptr <= {sess.addr[11:8], rx_byte};
              in_page <= rx_byte[4:0];
              lstate <= (sess.op == eeprom_pkg::OP_READ) ? eeprom_pkg::LK_RDATA
                                                          : eeprom_pkg::LK_WDATA;
            end
          end
          eeprom_pkg::LK_WDATA: begin
            load_mask[in_page] <= 1'b1;
            in_page <= next_in_page;
            sess.got_byte <= 1'b1;
          end
          eeprom_pkg::LK_STAT_IN: begin
            if (!got_b) begin
              sess.data <= rx_byte;
            end
            sess.got_byte <= 1'b1;
          end
          eeprom_pkg::LK_RDATA: begin
            rd_ptr <= rd_ptr + 12'h001;
          end
          default: begin
            lstate <= cur_state;
          end
        endcase
      end else begin
        lstate <= cur_state;
      end
    end
  end

  // page buffer holds bytes until the select rise
  always_ff @(posedge sck_i) begin
    if (hold_n_i && !cs_n_i && wr_byte) begin
      page_buf[in_page] <= rx_byte;
    end
  end

  // ----------------------------------------
  // link domain: output side
  // ----------------------------------------
  logic [7:0] tx_sh;
  logic so_drive;
  logic [7:0] mem [eeprom_pkg::ARRAY_BYTES];

  wire logic out_phase = (lstate == eeprom_pkg::LK_RDATA) ||
                         (lstate == eeprom_pkg::LK_STAT_OUT);
  wire logic tx_load = !fresh && out_phase && (bit_cnt == eeprom_pkg::FIRST_BIT);
  // array only changes while busy, when reads are refused
  wire logic [7:0] out_byte = (lstate == eeprom_pkg::LK_RDATA) ? mem[rd_ptr] : stat_link;

  always_ff @(negedge sck_i or posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i || cs_n_i) begin
      tx_sh <= 8'h00;
      so_drive <= 1'b0;
    end else if (hold_n_i) begin
      if (tx_load) begin
        tx_sh <= out_byte;
        so_drive <= 1'b1;
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  assign so_o = tx_sh[7];
  assign so_oe_n_o = cs_n_i || !hold_n_i || !so_drive;

  // ----------------------------------------
  // system domain: pin capture
  // ----------------------------------------
  logic cs_q;
  logic wp_q;
  logic cs_prev;
  logic wp_prev;
  logic wp_fell;

  eeprom_sync2 #(
    .W(2)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i({cs_n_i, wp_n_i}),
    .q_o({cs_q, wp_q})
  );

  wire logic cs_rise = cs_q && !cs_prev;
  wire logic cs_fall = !cs_q && cs_prev;

  // ----------------------------------------
  // system domain: status and protection
  // ----------------------------------------
  logic busy;
  logic write_enable_latch;
  logic [1:0] bg;
  logic pge;
  logic [CNT_W-1:0] cnt;

  wire logic hw_prot = !wp_q && pge;
  wire logic wp_drop = pge && !cs_q && wp_prev && !wp_q;
  wire logic sess_ok = cs_rise && sess.aligned;
  wire logic done = busy && (cnt == '0);
  wire logic do_set = sess_ok && (sess.op == eeprom_pkg::OP_SET) && !sess.extra;
  wire logic do_clear = sess_ok && (sess.op == eeprom_pkg::OP_CLEAR) && !sess.extra;
  wire logic page_guarded = eeprom_pkg::guarded(sess.addr, bg);
  wire logic do_write = sess_ok && (sess.op == eeprom_pkg::OP_WRITE) && sess.got_byte &&
                        write_enable_latch && !page_guarded;
  wire logic do_wrstat = sess_ok && (sess.op == eeprom_pkg::OP_WRSTAT) && sess.got_byte &&
                         write_enable_latch && !hw_prot && !wp_fell;
  wire logic start = do_write || do_wrstat;
  wire logic [7:0] status_byte;

  assign status_byte[eeprom_pkg::BIT_BUSY] = busy;
  assign status_byte[eeprom_pkg::BIT_WEL] = write_enable_latch;
  assign status_byte[eeprom_pkg::BIT_BG0] = bg[0];
  assign status_byte[eeprom_pkg::BIT_BG1] = bg[1];
  assign status_byte[6:4] = eeprom_pkg::STATUS_ZEROS;
  assign status_byte[eeprom_pkg::BIT_PGE] = pge;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_prev <= 1'b1;
      wp_prev <= 1'b1;
      wp_fell <= 1'b0;
    end else begin
      cs_prev <= cs_q;
      wp_prev <= wp_q;
      if (wp_drop) begin
        wp_fell <= 1'b1;
      end else if (cs_fall) begin
        wp_fell <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy <= 1'b0;
      cnt <= '0;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= CNT_W'(WRITE_CYCLES - 1);
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_enable_latch <= 1'b0;
    end else if (do_set) begin
      write_enable_latch <= 1'b1;
    end else if (do_clear || done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bg <= eeprom_pkg::GUARD_NONE;
      pge <= 1'b0;
    end else if (do_wrstat) begin
      bg <= {sess.data[eeprom_pkg::BIT_BG1], sess.data[eeprom_pkg::BIT_BG0]};
      pge <= sess.data[eeprom_pkg::BIT_PGE];
    end
  end

  // loaded page bytes land in the array at the start of the cycle
  always_ff @(posedge clk_sys_i) begin
    if (do_write) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (load_mask[i]) begin
          mem[{sess.addr[11:5], 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  eeprom_sync2 #(
    .W(8)
  ) u_stat_sync (
    .clk_i(sck_i),
    .resetn_i(resetn_i),
    .d_i(status_byte),
    .q_o(stat_link)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cycle_start;
    !busy ##1 busy;
  endsequence

  property p_busy_len;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    s_cycle_start |-> busy [*4];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");

  property p_wel_done;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $fell(busy) |-> !write_enable_latch;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after write");

  property p_guarded_refused;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && sess.op == eeprom_pkg::OP_WRITE && page_guarded) |=> !$rose(busy);
  endproperty
  a_guarded_refused: assert property (p_guarded_refused) else $error("guarded write ran");

  property p_latch_set;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && sess.aligned && !sess.extra && sess.op == eeprom_pkg::OP_SET) |=> write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && sess.aligned && !sess.extra && sess.op == eeprom_pkg::OP_CLEAR) |=> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_hw_guard;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && hw_prot && sess.op == eeprom_pkg::OP_WRSTAT) |=> $stable(bg) && $stable(pge);
  endproperty
  a_hw_guard: assert property (p_hw_guard) else $error("status written under guard");

  property p_wp_abort;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && wp_fell && sess.op == eeprom_pkg::OP_WRSTAT) |=> !$rose(busy);
  endproperty
  a_wp_abort: assert property (p_wp_abort) else $error("aborted status write ran");

  property p_start_on_rise;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(busy) |-> $past(cs_rise);
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("cycle without select rise");

  property p_no_latch_no_write;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cs_rise && !write_enable_latch) |=> !$rose(busy);
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write) else $error("write without latch");
endmodule
`default_nettype wire

// file: include/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  // ----------------------------------------
  // array and page geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int ARRAY_BYTES = 4096;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [11:0] QUARTER_BASE = 12'hC00;
  localparam logic [11:0] HALF_BASE = 12'h800;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CODE_LATCH_SET = 8'h06;
  localparam logic [7:0] CODE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CODE_STATUS_READ = 8'h05;
  localparam logic [7:0] CODE_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CODE_MEM_READ = 8'h03;
  localparam logic [7:0] CODE_MEM_WRITE = 8'h02;

  // ----------------------------------------
  // status byte layout
  // ----------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_BG0 = 2;
  localparam int BIT_BG1 = 3;
  localparam int BIT_PGE = 7;
  localparam logic [2:0] STATUS_ZEROS = 3'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_WRITE_NS = 5000000;
  localparam int WRITE_CYCLES_DEF = T_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE, OP_SET, OP_CLEAR, OP_RDSTAT, OP_WRSTAT, OP_READ, OP_WRITE
  } op_type;

  typedef enum logic [2:0] {
    LK_CMD, LK_ADDR, LK_RDATA, LK_WDATA, LK_STAT_OUT, LK_STAT_IN, LK_IGNORE
  } link_state_type;

  typedef struct packed {
    op_type op;
    logic aligned;
    logic extra;
    logic got_byte;
    logic [11:0] addr;
    logic [7:0] data;
  } session_type;

  function automatic op_type decode_op(input logic [7:0] code);
    unique case (code)
      CODE_LATCH_SET: decode_op = OP_SET;
      CODE_LATCH_CLEAR: decode_op = OP_CLEAR;
      CODE_STATUS_READ: decode_op = OP_RDSTAT;
      CODE_STATUS_WRITE: decode_op = OP_WRSTAT;
      CODE_MEM_READ: decode_op = OP_READ;
      CODE_MEM_WRITE: decode_op = OP_WRITE;
      default: decode_op = OP_NONE;
    endcase
  endfunction

  function automatic logic guarded(input logic [11:0] a, input logic [1:0] bg);
    unique case (bg)
      GUARD_NONE: guarded = 1'b0;
      GUARD_QUARTER: guarded = (a >= QUARTER_BASE);
      GUARD_HALF: guarded = (a >= HALF_BASE);
      default: guarded = 1'b1;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: tb/spi_eeprom_command_protect_tb_top.sv
`default_nettype none
module spi_eeprom_command_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wp_n = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe_n;
  logic so_line;
  logic [7:0] st;
  int failures = 0;
  int checks = 0;
  // released line shows the inverse of the last level
  assign so_line = so_oe_n ? ~so : so;
  spi_eeprom_command_protect #(.WRITE_CYCLES(60)) i_dut (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .so_o(so), .so_oe_n_o(so_oe_n), .wp_n_i(wp_n));
  spi_host_model i_host (
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so_line),
    .so_oe_n_i(so_oe_n));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic run(input int nbits);
    i_host.frame(nbits);
    #100;
  endtask
  task automatic op(input logic [7:0] c);
    i_host.tx = '{c};
    run(8);
  endtask
  task automatic status();
    i_host.tx = '{eeprom_pkg::CODE_STATUS_READ};
    run(16);
    st = i_host.rx[1];
  endtask
  task automatic ready();
    for (int n = 0; n < 40; n++) begin
      status();
      if (st[0] === 1'b0) return;
    end
    failures++;
    stop_test();
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0, input int extra);
    op(eeprom_pkg::CODE_LATCH_SET);
    i_host.tx = '{eeprom_pkg::CODE_MEM_WRITE, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) i_host.tx.push_back(d0 + 8'(i));
    run(24 + 8 * n + extra);
  endtask
  task automatic wsr(input logic [7:0] v);
    op(eeprom_pkg::CODE_LATCH_SET);
    i_host.tx = '{eeprom_pkg::CODE_STATUS_WRITE, v};
    run(16);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    i_host.tx = '{eeprom_pkg::CODE_MEM_READ, a[15:8], a[7:0]};
    run(24 + 8 * n);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    status();
    check("status after reset", st, 8'h00);
    i_host.tx = '{8'hAB, 8'h05};
    run(16);
    check("unknown code drive", 8'(i_host.driven), 8'h00);
    op(eeprom_pkg::CODE_LATCH_SET);
    status();
    check("latch set", st, 8'h02);
    op(eeprom_pkg::CODE_LATCH_CLEAR);
    status();
    check("latch clear", st, 8'h00);
    i_host.tx = '{eeprom_pkg::CODE_LATCH_SET};
    run(9);
    status();
    check("latch set long", st, 8'h00);
    i_host.tx = '{eeprom_pkg::CODE_MEM_WRITE, 8'h00, 8'h10, 8'h77};
    run(32);
    status();
    check("write no latch", st, 8'h00);
    wr(16'hF03C, 6, 8'h10, 0);
    status();
    check("busy after write", st, 8'h03);
    rd(16'h003C, 1);
    check("read while busy", 8'(i_host.driven), 8'h00);
    ready();
    check("latch after cycle", st, 8'h00);
    i_host.pause_at = 28;
    rd(16'h003C, 4);
    i_host.pause_at = -1;
    check("paused drive count", 8'(i_host.driven), 8'h20);
    for (int i = 0; i < 4; i++) check("page data", i_host.rx[3+i], 8'h10 + 8'(i));
    rd(16'h0020, 2);
    check("wrapped byte 0", i_host.rx[3], 8'h14);
    check("wrapped byte 1", i_host.rx[4], 8'h15);
    wr(16'h0100, 1, 8'h33, 4);
    status();
    check("partial byte", st, 8'h02);
    wr(16'h0FFF, 1, 8'hA5, 0);
    ready();
    wr(16'h0000, 1, 8'h5A, 0);
    ready();
    rd(16'h0FFF, 2);
    check("array top", i_host.rx[3], 8'hA5);
    check("array wrap", i_host.rx[4], 8'h5A);
    wsr(8'hFF);
    status();
    check("status write busy", st, 8'h8F);
    ready();
    check("status write mask", st, 8'h8C);
    wr(16'h0000, 1, 8'h11, 0);
    status();
    check("full guard", st, 8'h8E);
    @(posedge clk_sys);
    wp_n <= 1'b0;
    wsr(8'h00);
    status();
    check("pin guard", st, 8'h8E);
    @(posedge clk_sys);
    wp_n <= 1'b1;
    wsr(8'h84);
    ready();
    check("quarter guard set", st, 8'h84);
    wr(16'h0C00, 1, 8'h22, 0);
    status();
    check("quarter guarded", st, 8'h86);
    wr(16'h0BE0, 1, 8'h22, 0);
    status();
    check("below quarter", st, 8'h87);
    ready();
    op(eeprom_pkg::CODE_LATCH_SET);
    i_host.tx = '{eeprom_pkg::CODE_STATUS_WRITE, 8'h00};
    fork
      i_host.frame(16);
      begin
        repeat (4) @(posedge clk_sys);
        wp_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        wp_n <= 1'b1;
      end
    join
    #100;
    status();
    check("pin fall abort", st, 8'h86);
    wsr(8'h00);
    ready();
    i_host.mode3 = 1'b1;
    status();
    check("mode 3 status", st, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire

// file: tb/spi_host_model.sv
`default_nettype none
module spi_host_model (
  // link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic mode3 = 1'b0;
  int pause_at = -1;
  int driven;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // ----------------------------------------
  // one select session of nbits clocks
  // ----------------------------------------
  task automatic frame(input int nbits);
    logic [7:0] cur;
    logic [7:0] got;
    rx.delete();
    driven = 0;
    // settle the idle level first so no edge meets the select fall
    if (sck_o !== mode3) begin
      sck_o <= mode3;
      #12;
    end
    cs_n_o <= 1'b0;
    #12;
    for (int i = 0; i < nbits; i++) begin
      sck_o <= 1'b0;
      if (i == pause_at) begin
        // pause edges only while clock low
        #3 hold_n_o <= 1'b0;
        repeat (4) begin
          #6 si_o <= ~si_o;
          sck_o <= 1'b1;
          driven += (so_oe_n_i === 1'b0);
          #6 sck_o <= 1'b0;
        end
        #3 hold_n_o <= 1'b1;
      end
      if (i % 8 == 0) cur = (tx.size() > 0) ? tx.pop_front() : 8'h00;
      si_o <= cur[7];
      cur = cur << 1;
      #6 sck_o <= 1'b1;
      got = {got[6:0], so_i};
      driven += (so_oe_n_i === 1'b0);
      if (i % 8 == 7) rx.push_back(got);
      #6;
    end
    sck_o <= mode3;
    #6 cs_n_o <= 1'b1;
    si_o <= ~si_o;
  endtask
endmodule
`default_nettype wire
